/* File: cscc_pkg.sv */
`default_nettype none
package cscc_pkg;

    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int NCH = 4;
    localparam int TW = 10;
    localparam int NVM_WORDS = 9;
    localparam int NVIEW = 20;
    localparam int CLK_HZ = 10_000_000;
    localparam int BOOT_TIME_NS = 50_000;
    localparam int BOOT_CYC = (BOOT_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W = $clog2(BOOT_CYC + 1);

    // ----------------------------------------
    // Register offsets (byte addresses) and word indices within a channel
    // ----------------------------------------
    localparam logic [7:0] OFS_TRIG = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_SETUP = 8'h08;
    localparam logic [7:0] OFS_ACT = 8'h0C;
    localparam logic [7:0] OFS_CH0 = 8'h10;
    localparam logic [7:0] CH_STRIDE = 8'h10;
    localparam logic [1:0] CHW_SETUP = 2'h0;
    localparam logic [1:0] CHW_MODE = 2'h1;
    localparam logic [1:0] CHW_THR = 2'h2;
    localparam logic [1:0] CHW_MARG = 2'h3;

    // ----------------------------------------
    // Field positions, codes and reset values
    // ----------------------------------------
    localparam int TRG_STORE = 0;
    localparam int TRG_RESTORE = 1;
    localparam int TRG_RST_LSB = 4;
    localparam int TRG_KEY_LSB = 8;
    localparam logic [3:0] RST_CODE = 4'hA;
    localparam logic [3:0] KEY_CODE = 4'h5;
    localparam int ST_BUSY = 0;
    localparam int ST_ALM_USR = 1;
    localparam int ST_ALM_INT = 2;
    localparam int ST_RES_LSB = 8;
    localparam int SET_LOCK = 0;
    localparam int SET_PDN_LSB = 8;
    localparam int CHS_ON = 0;
    localparam int CHS_DRV = 1;
    localparam int CHS_OD = 2;
    localparam int CHS_INV = 3;
    localparam int CHS_HIZD = 4;
    localparam int MARG_HI_LSB = 16;
    localparam logic [7:0] FACT_PDN = 8'hFF;
    localparam logic [1:0] PDN_ON = 2'h0;
    localparam logic [1:0] PDN_10K = 2'h1;
    localparam logic [1:0] PDN_100K = 2'h2;
    localparam logic [1:0] MODE_PLAIN = 2'h0;
    localparam logic [1:0] MODE_HYST = 2'h1;
    localparam logic [1:0] MODE_LATCH = 2'h2;
    localparam logic [TW-1:0] CODE_FULL = 10'h3FF;
    localparam logic [TW-1:0] CODE_ZERO = 10'h000;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // ----------------------------------------
    // Image check
    // ----------------------------------------
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    // Internal trim word; value is arbitrary
    localparam logic [31:0] INT_WORD = 32'h0000_5AC3;

    // CRC-16-CCITT over one word, msb first
    function automatic logic [15:0] crc16_word(input logic [15:0] c, input logic [31:0] w);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            fb = r[15] ^ w[i];
            r = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    localparam logic [15:0] INT_CRC = crc16_word(CRC_INIT, INT_WORD);

    // Byte-lane merge of a bus write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] o, input logic [31:0] n,
                                               input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = n[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } cscc_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } cscc_axi_rsp_s;

    typedef struct packed {
        logic on;
        logic drv;
        logic od;
        logic inv;
        logic hizd;
        logic [1:0] mode;
        logic [TW-1:0] thr;
        logic [TW-1:0] mhi;
        logic [TW-1:0] mlo;
        logic [1:0] pdn;
    } cscc_chan_s;

endpackage
`default_nettype wire

/* File: cscc_cmp_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module cscc_cmp_chan
    import cscc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cscc_chan_s cfg_i,
    input wire logic [TW-1:0] ain_i,
    input wire logic clr_i,
    output logic res_o,
    output logic pin_o,
    output logic pin_oe_o,
    output logic pull_10k_o,
    output logic pull_100k_o,
    output logic ain_load_o
);

    // ----------------------------------------
    // Decision state
    // ----------------------------------------
    logic st_q;
    logic st_d;
    logic res;
    logic active;
    wire above = ain_i > cfg_i.thr;
    wire in_win = (ain_i >= cfg_i.mlo) && (ain_i <= cfg_i.mhi);
    wire hyst_latch = (cfg_i.mhi == CODE_FULL) || (cfg_i.mlo == CODE_ZERO);
    wire latch_md = (cfg_i.mode == MODE_LATCH) || ((cfg_i.mode == MODE_HYST) && hyst_latch);

    // Next decision per behaviour mode
    always_comb begin
        st_d = st_q;
        if (!cfg_i.on) begin
            st_d = 1'b0;
        end else if (latch_md) begin
            if (clr_i && in_win) begin
                st_d = 1'b0;
            end else if (above) begin
                st_d = 1'b1;
            end
        end else if (cfg_i.mode == MODE_HYST) begin
            if (ain_i > cfg_i.mhi) begin
                st_d = 1'b1;
            end else if (ain_i < cfg_i.mlo) begin
                st_d = 1'b0;
            end
        end else begin
            st_d = above;
        end
    end

    assign res = st_q ^ cfg_i.inv;
    assign active = cfg_i.on && cfg_i.drv && (cfg_i.pdn == PDN_ON);

    // Registered pin and result outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= 1'b0;
            res_o <= 1'b0;
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
            pull_10k_o <= 1'b0;
            pull_100k_o <= 1'b0;
            ain_load_o <= 1'b0;
        end else begin
            st_q <= st_d;
            res_o <= cfg_i.on & res;
            pin_o <= active & ~cfg_i.od & res;
            pin_oe_o <= active & (cfg_i.od ? ~res : 1'b1);
            pull_10k_o <= ~active & (cfg_i.pdn == PDN_10K);
            pull_100k_o <= ~active & (cfg_i.pdn == PDN_100K);
            ain_load_o <= cfg_i.hizd;
        end
    end

endmodule
`default_nettype wire

/* File: cscc_ctrl.sv */
// Decided for this implementation: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cscc_ctrl
    import cscc_pkg::*;
#(
    parameter logic [15:0] INT_CRC_REF = INT_CRC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cscc_axi_req_s axi_req_i,
    output var cscc_axi_rsp_s axi_rsp_o,
    input wire logic [NCH-1:0][TW-1:0] ain_i,
    input wire logic gc_reset_i,
    output var logic [NCH-1:0] lut_cmp_o,
    output var logic [NCH-1:0] cmp_pin_o,
    output var logic [NCH-1:0] cmp_pin_oe_o,
    output var logic [NCH-1:0] pull_10k_o,
    output var logic [NCH-1:0] pull_100k_o,
    output var logic [NCH-1:0] ain_load_o
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    typedef enum logic [2:0] {
        S_LOAD,
        S_APPLY,
        S_WAIT,
        S_IDLE,
        S_STORE
    } cscc_state_e;

    cscc_state_e st_q;
    logic [3:0] idx_q;
    logic [15:0] crc_q;
    logic [CNT_W-1:0] cnt_q;
    logic boot_q;
    logic alm_usr_q;
    logic alm_int_q;
    logic [31:0] nvm_q [NVM_WORDS] = '{default: 32'h0}; // Erased image reads as zeros
    logic [15:0] nvm_crc_q = 16'h0000; // A zero image never checks against this

    logic lock_q;
    logic [7:0] pdn_q;
    logic [4:0] chs_q [NCH];
    logic [1:0] mode_q [NCH];
    logic [TW-1:0] thr_q [NCH];
    logic [TW-1:0] mhi_q [NCH];
    logic [TW-1:0] mlo_q [NCH];
    logic store_q;
    logic restore_q;
    logic bypass_q;
    logic soft_q;
    logic [NCH-1:0] clr_q;

    logic aw_rdy_q;
    logic aw_full_q;
    logic [7:0] aw_addr_q;
    logic w_rdy_q;
    logic w_full_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic b_valid_q;
    logic [1:0] b_resp_q;
    logic ar_rdy_q;
    logic r_valid_q;
    logic [31:0] r_data_q;
    logic [1:0] r_resp_q;

    logic [NCH-1:0][TW-1:0] ain_s1_q;
    logic [NCH-1:0][TW-1:0] ain_s2_q;
    logic [31:0] view [NVIEW];
    logic [31:0] img [NVM_WORDS];
    cscc_chan_s cfg [NCH];

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    // Reset sources: pin reset, register code or general call
    wire init = rst_i | soft_q;
    wire busy = st_q != S_IDLE;
    wire last = idx_q == 4'(NVM_WORDS - 1);
    wire [15:0] crc_nx = crc16_word(crc_q, (st_q == S_STORE) ? img[idx_q] : nvm_q[idx_q]);
    wire img_ok = crc_q == nvm_crc_q;
    wire int_ok = INT_CRC == INT_CRC_REF;
    wire apply_go = (st_q == S_APPLY) && img_ok && (int_ok || !boot_q);

    // Write address decode
    wire [4:0] widx = aw_addr_q[6:2];
    wire w_map = (aw_addr_q[1:0] == 2'h0) && !aw_addr_q[7] && (widx < 5'(NVIEW));
    wire do_wr = aw_full_q && w_full_q && !b_valid_q;
    wire wr_ok = do_wr && w_map && !busy;
    wire unlocked = !lock_q || bypass_q;
    wire wr_cfg = wr_ok && unlocked;
    wire [31:0] wnew = lane_merge(view[widx], w_data_q, w_strb_q);
    wire w_trig = aw_addr_q == OFS_TRIG;
    wire w_setup = aw_addr_q == OFS_SETUP;
    wire w_act = aw_addr_q == OFS_ACT;
    wire w_ch = aw_addr_q >= OFS_CH0;
    wire [1:0] wch = 2'(aw_addr_q[7:4] - 4'h1);
    wire [1:0] wwd = aw_addr_q[3:2];
    wire rst_cmd = wr_cfg && w_trig && (wnew[TRG_RST_LSB +: 4] == RST_CODE);
    wire key_cmd = wr_ok && w_trig && (wnew[TRG_KEY_LSB +: 4] == KEY_CODE);

    // Read address decode
    wire [4:0] ridx = axi_req_i.araddr[6:2];
    wire r_map = (axi_req_i.araddr[1:0] == 2'h0) && !axi_req_i.araddr[7]
                 && (ridx < 5'(NVIEW));
    wire ar_take = ar_rdy_q && axi_req_i.arvalid;
    wire aw_take = aw_rdy_q && axi_req_i.awvalid;
    wire w_take = w_rdy_q && axi_req_i.wvalid;
    wire aw_nx = aw_full_q ? !do_wr : aw_take;
    wire w_nx = w_full_q ? !do_wr : w_take;
    wire r_nx = ar_take || (r_valid_q && !axi_req_i.rready);

    // ----------------------------------------
    // Register view and stored image words
    // ----------------------------------------
    // Common words of the register view
    assign view[0] = {30'h0, restore_q, store_q};
    assign view[1] = {20'h0, lut_cmp_o, 5'h0, alm_int_q, alm_usr_q, busy};
    assign view[2] = {16'h0, pdn_q, 7'h0, lock_q};
    assign view[3] = 32'h0;
    assign img[0] = view[2];

    // Per-channel words and channel configuration
    for (genvar c = 0; c < NCH; c++) begin : g_view
        assign view[4 + 4*c] = {27'h0, chs_q[c]};
        assign view[5 + 4*c] = {30'h0, mode_q[c]};
        assign view[6 + 4*c] = {22'h0, thr_q[c]};
        assign view[7 + 4*c] = {6'h0, mhi_q[c], 6'h0, mlo_q[c]};
        assign img[1 + c] = view[4 + 4*c];
        assign img[1 + NCH + c] = view[6 + 4*c];
        assign cfg[c] = '{on: chs_q[c][CHS_ON], drv: chs_q[c][CHS_DRV],
                          od: chs_q[c][CHS_OD], inv: chs_q[c][CHS_INV],
                          hizd: chs_q[c][CHS_HIZD], mode: mode_q[c], thr: thr_q[c],
                          mhi: mhi_q[c], mlo: mlo_q[c], pdn: pdn_q[2*c +: 2]};
    end

    // ----------------------------------------
    // Load, check and store sequencer
    // ----------------------------------------
    // Walks the image word by word and keeps the running CRC
    always_ff @(posedge clk_i) begin
        if (init) begin
            st_q <= S_LOAD;
            idx_q <= 4'h0;
            crc_q <= CRC_INIT;
            cnt_q <= '0;
            boot_q <= 1'b1;
            alm_usr_q <= 1'b0;
            alm_int_q <= 1'b0;
        end else begin
            unique case (st_q)
                S_LOAD: begin
                    crc_q <= crc_nx;
                    idx_q <= idx_q + 4'h1;
                    if (last) begin
                        st_q <= S_APPLY;
                    end
                end
                S_APPLY: begin
                    idx_q <= 4'h0;
                    if (boot_q) begin
                        alm_usr_q <= !img_ok;
                        alm_int_q <= !int_ok;
                        st_q <= S_WAIT;
                    end else begin
                        st_q <= S_IDLE;
                    end
                end
                S_WAIT: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == CNT_W'(BOOT_CYC - 1)) begin
                        st_q <= S_IDLE;
                    end
                end
                S_IDLE: begin
                    crc_q <= CRC_INIT;
                    idx_q <= 4'h0;
                    if (store_q) begin
                        st_q <= S_STORE;
                    end else if (restore_q) begin
                        boot_q <= 1'b0;
                        st_q <= S_LOAD;
                    end
                end
                S_STORE: begin
                    crc_q <= crc_nx;
                    idx_q <= idx_q + 4'h1;
                    if (last) begin
                        st_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Nonvolatile image; survives every reset
    always_ff @(posedge clk_i) begin
        if (st_q == S_STORE) begin
            nvm_q[idx_q] <= img[idx_q];
            if (last) begin
                nvm_crc_q <= crc_nx;
            end
        end
    end

    // ----------------------------------------
    // Trigger, key and reset flags
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (init) begin
            store_q <= 1'b0;
            restore_q <= 1'b0;
            bypass_q <= 1'b0;
            clr_q <= '0;
        end else begin
            if (st_q == S_STORE && last) begin
                store_q <= 1'b0;
            end else if (wr_cfg && w_trig && wnew[TRG_STORE]) begin
                store_q <= 1'b1;
            end
            if (st_q == S_APPLY && !boot_q) begin
                restore_q <= 1'b0;
            end else if (wr_cfg && w_trig && wnew[TRG_RESTORE]) begin
                restore_q <= 1'b1;
            end
            if (key_cmd) begin
                bypass_q <= 1'b1;
            end
            clr_q <= (wr_cfg && w_act) ? wnew[NCH-1:0] : '0;
        end
    end

    // Software reset pulse; lasts one cycle after the reset code or general call, and the pin reset also clears it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_q <= 1'b0;
        end else begin
            soft_q <= rst_cmd | gc_reset_i;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (init) begin
            lock_q <= 1'b0;
            pdn_q <= FACT_PDN;
            for (int c = 0; c < NCH; c++) begin
                chs_q[c] <= 5'h0;
                mode_q[c] <= MODE_PLAIN;
                thr_q[c] <= CODE_ZERO;
                mhi_q[c] <= CODE_ZERO;
                mlo_q[c] <= CODE_ZERO;
            end
        end else if (apply_go) begin
            lock_q <= nvm_q[0][SET_LOCK];
            pdn_q <= nvm_q[0][SET_PDN_LSB +: 8];
            for (int c = 0; c < NCH; c++) begin
                chs_q[c] <= nvm_q[1 + c][4:0];
                thr_q[c] <= nvm_q[1 + NCH + c][TW-1:0];
                mode_q[c] <= MODE_PLAIN;
            end
        end else if (wr_cfg) begin
            if (w_setup) begin
                lock_q <= wnew[SET_LOCK];
                pdn_q <= wnew[SET_PDN_LSB +: 8];
            end
            if (w_ch && wwd == CHW_SETUP) begin
                chs_q[wch] <= wnew[4:0];
            end
            if (w_ch && wwd == CHW_MODE) begin
                mode_q[wch] <= wnew[1:0];
            end
            if (w_ch && wwd == CHW_THR) begin
                thr_q[wch] <= wnew[TW-1:0];
            end
            if (w_ch && wwd == CHW_MARG) begin
                mhi_q[wch] <= wnew[MARG_HI_LSB +: TW];
                mlo_q[wch] <= wnew[TW-1:0];
            end
        end
    end

    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    // Address and data channels, taken in either order
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_rdy_q <= 1'b0;
            aw_full_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_rdy_q <= 1'b0;
            w_full_q <= 1'b0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
        end else begin
            aw_full_q <= aw_nx;
            aw_rdy_q <= !aw_nx;
            w_full_q <= w_nx;
            w_rdy_q <= !w_nx;
            if (aw_take) begin
                aw_addr_q <= axi_req_i.awaddr;
            end
            if (w_take) begin
                w_data_q <= axi_req_i.wdata;
                w_strb_q <= axi_req_i.wstrb;
            end
        end
    end

    // Write response; unmapped writes and writes while busy answer an error, locked writes answer OK
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            b_valid_q <= 1'b0;
            b_resp_q <= RESP_OK;
        end else if (do_wr) begin
            b_valid_q <= 1'b1;
            b_resp_q <= wr_ok ? RESP_OK : RESP_ERR;
        end else if (axi_req_i.bready) begin
            b_valid_q <= 1'b0;
        end
    end

    // Read channel; data captured at the address handshake
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ar_rdy_q <= 1'b0;
            r_valid_q <= 1'b0;
            r_data_q <= 32'h0;
            r_resp_q <= RESP_OK;
        end else begin
            ar_rdy_q <= !r_nx;
            r_valid_q <= r_nx;
            if (ar_take) begin
                r_data_q <= (r_map && !busy) ? view[ridx] : 32'h0;
                r_resp_q <= (r_map && !busy) ? RESP_OK : RESP_ERR;
            end
        end
    end

    // Response carrier straight from the flops
    assign axi_rsp_o = '{awready: aw_rdy_q, wready: w_rdy_q, bresp: b_resp_q,
                         bvalid: b_valid_q, arready: ar_rdy_q, rdata: r_data_q,
                         rresp: r_resp_q, rvalid: r_valid_q};

    // ----------------------------------------
    // Input synchronisers and comparator channels
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ain_s1_q <= '0;
            ain_s2_q <= '0;
        end else begin
            ain_s1_q <= ain_i;
            ain_s2_q <= ain_s1_q;
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_chan
        cscc_cmp_chan u_chan (
            .clk_i(clk_i),
            .rst_i(init),
            .cfg_i(cfg[c]),
            .ain_i(ain_s2_q[c]),
            .clr_i(clr_q[c]),
            .res_o(lut_cmp_o[c]),
            .pin_o(cmp_pin_o[c]),
            .pin_oe_o(cmp_pin_oe_o[c]),
            .pull_10k_o(pull_10k_o[c]),
            .pull_100k_o(pull_100k_o[c]),
            .ain_load_o(ain_load_o[c])
        );
    end

endmodule
`default_nettype wire

/* File: cscc_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module cscc_assertions
    import cscc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire cscc_axi_req_s axi_req_i,
    input wire cscc_axi_rsp_s axi_rsp_o,
    input wire logic gc_reset_i,
    input wire logic [NCH-1:0] lut_cmp_o,
    input wire logic [NCH-1:0] cmp_pin_o,
    input wire logic [NCH-1:0] cmp_pin_oe_o,
    input wire logic [NCH-1:0] pull_10k_o,
    input wire logic [NCH-1:0] pull_100k_o
);
    // Cycles since reset release, saturating
    logic [9:0] age_q;
    always_ff @(posedge clk_i) age_q <= rst_i ? 10'h000 : age_q + 10'(age_q != 10'h3FF);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_pull_excl: assert property ((pull_10k_o & pull_100k_o) == 4'h0) else $error("two pulls");
    a_pull_float: assert property (((pull_10k_o | pull_100k_o) & cmp_pin_oe_o) == 4'h0)
        else $error("pull while driving");
    a_pin_drive: assert property ((cmp_pin_o & ~cmp_pin_oe_o) == 4'h0) else $error("pin undriven");
    a_read_lat: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
        else $error("late read");
    a_rdata_hold: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=>
        axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata)) else $error("read dropped");
    a_boot_busy: assert property (axi_rsp_o.rvalid && age_q < 10'h1F4 |->
        axi_rsp_o.rresp == RESP_ERR) else $error("access during boot");
    a_gc_reset: assert property (gc_reset_i |-> ##[1:3] cmp_pin_oe_o == 4'h0)
        else $error("no reset");
    a_reset_quiet: assert property ($fell(rst_i) |-> lut_cmp_o == 4'h0 && !axi_rsp_o.rvalid)
        else $error("outputs after reset");
endmodule
bind cscc_ctrl cscc_assertions u_cscc_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .gc_reset_i(gc_reset_i),
    .lut_cmp_o(lut_cmp_o), .cmp_pin_o(cmp_pin_o), .cmp_pin_oe_o(cmp_pin_oe_o),
    .pull_10k_o(pull_10k_o), .pull_100k_o(pull_100k_o));
`default_nettype wire

/* File: cscc_ain_src.sv */
`timescale 1ns/1ps
`default_nettype none
module cscc_ain_src
    import cscc_pkg::*;
(
    input wire logic clk_i,
    input wire logic [TW-1:0] level_i,
    output logic [NCH-1:0][TW-1:0] ain_o
);
    // Input level settles one clock after a change
    always_ff @(posedge clk_i) ain_o <= {NCH{level_i}};
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import cscc_pkg::*;
    localparam logic [7:0] THR = 8'h18;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic gc = 1'b0;
    cscc_axi_req_s req = '0;
    cscc_axi_rsp_s rsp;
    logic [NCH-1:0][TW-1:0] ain;
    logic [NCH-1:0] lut, pin, oe, ld;
    logic [TW-1:0] lvl = 10'h200;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    always #50 clk_i = ~clk_i;
    cscc_ain_src u_cscc_ain_src (.clk_i(clk_i), .level_i(lvl), .ain_o(ain));
    cscc_ctrl u_cscc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .axi_req_i(req), .axi_rsp_o(rsp),
        .ain_i(ain), .gc_reset_i(gc), .lut_cmp_o(lut), .cmp_pin_o(pin), .cmp_pin_oe_o(oe),
        .pull_10k_o(), .pull_100k_o(), .ain_load_o(ld));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
        end
    endtask
    // Bus write, each channel released on its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= '{awaddr: a, awvalid: 1'b1, wdata: d, wstrb: 4'hF, wvalid: 1'b1, bready: 1'b1,
            default: '0};
        do begin
            @(posedge clk_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
        req.bready <= 1'b0;
        chk(32'(rsp.bresp), 32'(RESP_OK));
    endtask
    // Bus read; rready rises one edge after rvalid, so rvalid must hold meanwhile
    task automatic rd(input logic [7:0] a, input logic [1:0] e, input logic [31:0] v);
        @(posedge clk_i);
        req <= '{araddr: a, arvalid: 1'b1, default: '0};
        do begin
            @(posedge clk_i);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
        req.rready <= 1'b1;
        @(posedge clk_i);
        req.rready <= 1'b0;
        chk(32'(rsp.rresp), 32'(e));
        chk(rsp.rdata, v);
    endtask
    // New input level, then time for the partner, synchroniser and channel flops
    task automatic lv(input logic [TW-1:0] v);
        lvl <= v;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic wrap_up;
        $display("mismatches %0d compares %0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_STAT, RESP_ERR, 32'h0);
        repeat (520) @(posedge clk_i);
        rd(OFS_STAT, RESP_OK, 32'h2);
        rd(OFS_SETUP, RESP_OK, 32'h0000FF00);
        wr(OFS_SETUP, 32'h0000FC00);
        wr(THR, 32'h100);
        wr(OFS_CH0, 32'hB);
        repeat (6) @(posedge clk_i);
        chk(32'({lut[0], pin[0], oe[0]}), 32'h1);
        wr(OFS_CH0, 32'h13);
        repeat (6) @(posedge clk_i);
        chk(32'({lut[0], pin[0], oe[0]}), 32'h7);
        wr(OFS_TRIG, 32'h1);
        rd(OFS_TRIG, RESP_ERR, 32'h0);
        repeat (20) @(posedge clk_i);
        rd(OFS_TRIG, RESP_OK, 32'h0);
        rd(OFS_STAT, RESP_OK, 32'h102);
        wr(THR, 32'h300);
        wr(OFS_TRIG, 32'h2);
        repeat (20) @(posedge clk_i);
        rd(THR, RESP_OK, 32'h100);
        wr(OFS_SETUP, 32'h0000FC01);
        wr(THR, 32'h55);
        rd(THR, RESP_OK, 32'h100);
        wr(OFS_TRIG, 32'h500);
        wr(THR, 32'h55);
        rd(THR, RESP_OK, 32'h55);
        wr(OFS_TRIG, 32'hA0);
        repeat (520) @(posedge clk_i);
        rd(OFS_STAT, RESP_OK, 32'h100);
        rd(THR, RESP_OK, 32'h100);
        chk(32'(ld[0]), 32'h1);
        wr(THR, 32'h300);
        wr(OFS_CH0 + 8'h0C, 32'h0280_0180);
        wr(OFS_CH0 + 8'h04, 32'h1);
        lv(10'h300);
        lv(10'h200);
        chk(32'(lut[0]), 32'h1);
        lv(10'h100);
        chk(32'(lut[0]), 32'h0);
        wr(OFS_CH0 + 8'h04, 32'h2);
        lv(10'h380);
        lv(10'h200);
        chk(32'(lut[0]), 32'h1);
        wr(OFS_ACT, 32'h1);
        repeat (8) @(posedge clk_i);
        chk(32'(lut[0]), 32'h0);
        gc <= 1'b1;
        @(posedge clk_i);
        gc <= 1'b0;
        rd(OFS_STAT, RESP_ERR, 32'h0);
        wrap_up();
    end
endmodule
`default_nettype wire
